// ### lpr_pkg.sv
package lpr_pkg;
   localparam longint unsigned CLK_HZ = 64'd200000000;
   // nominal times in microseconds
   localparam longint unsigned DELAY_SEL_LOW_US = 64'd7500000;
   localparam longint unsigned DELAY_SEL_HIGH_US = 64'd11250000;
   localparam longint unsigned DELAY_FIXED_A_US = 64'd7500000;
   localparam longint unsigned DELAY_FIXED_B_US = 64'd10000000;
   localparam longint unsigned DELAY_FIXED_C_US = 64'd3000000;
   localparam longint unsigned RELEASE_A_US = 64'd234000;
   localparam longint unsigned RELEASE_B_US = 64'd313000;
   localparam longint unsigned RELEASE_C_US = 64'd78000;
   localparam longint unsigned RELEASE_D_US = 64'd187500;
   localparam longint unsigned TICK_US = 64'd1;
   localparam int TICK_CYCLES = int'((TICK_US * CLK_HZ) / 64'd1000000);
   localparam int CNT_W = 32;
   localparam logic [CNT_W-1:0] DELAY_SEL_LOW_T = CNT_W'(DELAY_SEL_LOW_US / TICK_US);
   localparam logic [CNT_W-1:0] DELAY_SEL_HIGH_T = CNT_W'(DELAY_SEL_HIGH_US / TICK_US);
   localparam logic [CNT_W-1:0] DELAY_FIXED_T = CNT_W'(DELAY_FIXED_A_US / TICK_US);
   localparam logic [CNT_W-1:0] RELEASE_T = CNT_W'(RELEASE_A_US / TICK_US);
   localparam int TICK_W = 8;
   typedef enum logic [1:0] {
      ST_IDLE,
      ST_TIMING,
      ST_ASSERT,
      ST_DONE
   } lpr_state_e;
endpackage

// ### tick_if.sv
`timescale 1ns/1ps
interface tick_if;
   logic clear;
   logic tick;
   modport gen(input clear, output tick);
   modport use_(output clear, input tick);
endinterface

// ### tick_gen.sv
`timescale 1ns/1ps
module tick_gen
   import lpr_pkg::*;
#(
   parameter int DIV = TICK_CYCLES
) (
   input wire logic clk,
   input wire logic reset,
   input wire logic clkEn,
   tick_if.gen tb
);
   logic [TICK_W-1:0] div_q;
   logic [TICK_W-1:0] div_d;
   logic tick_q;
   logic tick_d;
   localparam logic [TICK_W-1:0] DIV_LAST = TICK_W'(DIV - 1);

   always_comb begin
      div_d = div_q + 1'b1;
      tick_d = 1'b0;
      if (tb.clear) begin
         div_d = '0;
      end else if (div_q == DIV_LAST) begin
         div_d = '0;
         tick_d = 1'b1;
      end
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         div_q <= '0;
         tick_q <= 1'b0;
      end else if (clkEn) begin
         div_q <= div_d;
         tick_q <= tick_d;
      end
   end

   assign tb.tick = tick_q & clkEn;
endmodule

// ### long_press_reset_timer.sv
`timescale 1ns/1ps
// Function
// - run timer only while both keys low
// - assert reset after full uninterrupted delay
// - key release stops timer, restart from zero
// - latching: hold reset while both keys low
// - latching: select picks long or short delay
// - auto-release: end after release time or release
module long_press_reset_timer
   import lpr_pkg::*;
#(
   parameter bit LATCHING = 1'b1,
   parameter logic [CNT_W-1:0] DELAY_LOW_TICKS = DELAY_SEL_LOW_T,
   parameter logic [CNT_W-1:0] DELAY_HIGH_TICKS = DELAY_SEL_HIGH_T,
   parameter logic [CNT_W-1:0] FIXED_DELAY_TICKS = DELAY_FIXED_T,
   parameter logic [CNT_W-1:0] RELEASE_TICKS = RELEASE_T,
   parameter int TICK_DIV = TICK_CYCLES
) (
   input wire logic clk,
   input wire logic reset,
   input wire logic clkEn,
   input wire logic key_in_a_n,
   input wire logic key_in_b_n,
   input wire logic delaySelect,
   output logic resetOut,
   output logic reset_out_second,
   output logic timerRunning
);
   tick_if tb();
   lpr_state_e state_q;
   lpr_state_e state_d;
   logic [CNT_W-1:0] cnt_q;
   logic [CNT_W-1:0] cnt_d;
   logic selLatched_q;
   logic selLatched_d;
   logic selTaken_q;
   logic selTaken_d;
   logic resetOut_q;
   logic resetOut_d;
   logic [CNT_W-1:0] delayTarget;
   logic bothLow;

   tick_gen #(.DIV(TICK_DIV)) uTick (
      .clk(clk),
      .reset(reset),
      .clkEn(clkEn),
      .tb(tb)
   );

   assign bothLow = ~key_in_a_n & ~key_in_b_n;

   // delay select; select sampled once after reset, stable thereafter
   assign delayTarget = !LATCHING ? FIXED_DELAY_TICKS :
                        (selLatched_q ? DELAY_HIGH_TICKS : DELAY_LOW_TICKS);

   always_comb begin
      selTaken_d = 1'b1;
      selLatched_d = selTaken_q ? selLatched_q : delaySelect;
   end

   always_comb begin
      state_d = state_q;
      cnt_d = cnt_q;
      resetOut_d = 1'b0;
      tb.clear = 1'b0;
      case (state_q)
         ST_IDLE: begin
            cnt_d = '0;
            tb.clear = 1'b1;
            if (bothLow) begin
               state_d = ST_TIMING;
            end
         end
         ST_TIMING: begin
            if (!bothLow) begin
               state_d = ST_IDLE;
               cnt_d = '0;
               tb.clear = 1'b1;
            end else if (tb.tick) begin
               if (cnt_q == delayTarget - 1'b1) begin
                  state_d = ST_ASSERT;
                  cnt_d = '0;
                  resetOut_d = 1'b1;
               end else begin
                  cnt_d = cnt_q + 1'b1;
               end
            end
         end
         ST_ASSERT: begin
            resetOut_d = 1'b1;
            if (!bothLow) begin
               state_d = ST_IDLE;
               cnt_d = '0;
               resetOut_d = 1'b0;
            end else if (!LATCHING && tb.tick) begin
               if (cnt_q == RELEASE_TICKS - 1'b1) begin
                  state_d = ST_DONE;
                  cnt_d = '0;
                  resetOut_d = 1'b0;
               end else begin
                  cnt_d = cnt_q + 1'b1;
               end
            end
         end
         ST_DONE: begin
            cnt_d = '0;
            tb.clear = 1'b1;
            if (!bothLow) begin
               state_d = ST_IDLE;
            end
         end
         default: begin
            state_d = ST_IDLE;
            cnt_d = '0;
         end
      endcase
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         state_q <= ST_IDLE;
         cnt_q <= '0;
         resetOut_q <= 1'b0;
         selLatched_q <= 1'b0;
         selTaken_q <= 1'b0;
      end else if (clkEn) begin
         state_q <= state_d;
         cnt_q <= cnt_d;
         resetOut_q <= resetOut_d;
         selLatched_q <= selLatched_d;
         selTaken_q <= selTaken_d;
      end
   end

   assign resetOut = resetOut_q;
   assign reset_out_second = resetOut_q;
   assign timerRunning = (state_q == ST_TIMING);

   sequence s_release;
      !bothLow;
   endsequence

   sequence s_idle_next;
      ##1 (!clkEn || state_q == ST_IDLE);
   endsequence

   a_idle_stays_low: assert property (@(posedge clk) disable iff (reset)
      (state_q == ST_IDLE && !bothLow && clkEn) |=> state_q == ST_IDLE)
      else $error("timer left idle without both keys low");

   a_start_runs: assert property (@(posedge clk) disable iff (reset)
      (state_q == ST_IDLE && bothLow && clkEn) |=> timerRunning && cnt_q == '0)
      else $error("both keys low did not start timer");

   a_reset_needs_count: assert property (@(posedge clk) disable iff (reset)
      ($rose(resetOut) && $past(clkEn)) |-> $past(state_q) == ST_TIMING
         && $past(cnt_q) == delayTarget - 1'b1)
      else $error("reset asserted before delay elapsed");

   a_timer_no_reset: assert property (@(posedge clk) disable iff (reset)
      timerRunning |-> !resetOut)
      else $error("reset asserted while delay still running");

   a_second_pin: assert property (@(posedge clk) disable iff (reset)
      reset_out_second == resetOut)
      else $error("second reset pin differs from first");

   a_abort_clears: assert property (@(posedge clk) disable iff (reset)
      (state_q == ST_TIMING && clkEn) ##0 s_release |=> cnt_q == '0 && !resetOut)
      else $error("release during delay did not clear timer");

   a_run_flag: assert property (@(posedge clk) disable iff (reset)
      (timerRunning && !bothLow && clkEn) |=> !timerRunning)
      else $error("timer kept running after key release");

   a_release_ends: assert property (@(posedge clk) disable iff (reset)
      (resetOut && clkEn) ##0 s_release |-> s_idle_next)
      else $error("reset not released on key release");

   a_latch_holds: assert property (@(posedge clk) disable iff (reset)
      (LATCHING && resetOut && bothLow && clkEn) |=> resetOut)
      else $error("latched reset dropped while keys held");

   a_select_stable: assert property (@(posedge clk) disable iff (reset)
      $past(selTaken_q) |-> $stable(selLatched_q))
      else $error("delay select changed after capture");

   a_auto_release: assert property (@(posedge clk) disable iff (reset)
      ($fell(resetOut) && $past(bothLow)) |-> !LATCHING && $past(state_q) == ST_ASSERT
         && $past(cnt_q) == RELEASE_TICKS - 1'b1)
      else $error("auto release at wrong time");

   a_auto_holds: assert property (@(posedge clk) disable iff (reset)
      (!LATCHING && resetOut && bothLow && clkEn && cnt_q < RELEASE_TICKS - 1'b1) |=> resetOut)
      else $error("auto reset ended before release time");

   a_done_ignores: assert property (@(posedge clk) disable iff (reset)
      (state_q == ST_DONE && bothLow && clkEn) |=> state_q == ST_DONE && !resetOut)
      else $error("re-press during done restarted timer");

   a_count_bounded: assert property (@(posedge clk) disable iff (reset)
      state_q == ST_TIMING |-> cnt_q < delayTarget)
      else $error("delay count past target");

   a_count_step: assert property (@(posedge clk) disable iff (reset)
      (state_q == ST_TIMING && bothLow && clkEn && !tb.tick) |=> $stable(cnt_q))
      else $error("delay count moved without a tick");

   a_idle_cnt_zero: assert property (@(posedge clk) disable iff (reset)
      state_q == ST_IDLE |-> cnt_q == '0 && !resetOut)
      else $error("idle with nonzero count");

   a_freeze_state: assert property (@(posedge clk) disable iff (reset)
      !clkEn |=> $stable(state_q) && $stable(cnt_q) && $stable(resetOut))
      else $error("state moved while clock enable low");

   a_reset_clears: assert property (@(posedge clk)
      reset |=> cnt_q == '0 && !resetOut && !timerRunning)
      else $error("reset left timer state behind");
endmodule

// ### key_press_model.sv
`timescale 1ns/1ps
module key_press_model (
   input wire logic clk,
   input wire logic holdA,
   input wire logic holdB,
   input wire logic cpuReset,
   output logic key_in_a_n,
   output logic key_in_b_n,
   output logic [7:0] resetCount
);
   logic seen_q;
   initial begin
      key_in_a_n = 1'b1;
      key_in_b_n = 1'b1;
      resetCount = 8'h00;
      seen_q = 1'b0;
   end
   // keys active low: a held key grounds its line, a free one is pulled up
   always @(posedge clk) begin
      key_in_a_n <= ~holdA;
      key_in_b_n <= ~holdB;
      seen_q <= cpuReset;
      if (cpuReset && !seen_q) begin
         resetCount <= resetCount + 8'h01;
      end
   end
endmodule

// ### tb_long_press_reset_timer.sv
`timescale 1ns/1ps
module tb_long_press_reset_timer;
   import lpr_pkg::*;
   localparam int DIV = 2;
   localparam int DLO = 10;
   localparam int DHI = 15;
   localparam int REL = 4;
   logic clk, reset, clkEn, delaySelect, holdA, holdB, keyA_n, keyB_n;
   logic latchOut, latchOut2, latchRun, autoOut;
   logic [7:0] pulses;
   logic [31:0] seed;
   int bad_count, checks, n, i, expPulses, r, f;
   key_press_model partner (.clk(clk), .holdA(holdA), .holdB(holdB), .cpuReset(latchOut),
      .key_in_a_n(keyA_n), .key_in_b_n(keyB_n), .resetCount(pulses));
   long_press_reset_timer #(.LATCHING(1'b1), .DELAY_LOW_TICKS(CNT_W'(DLO)),
      .DELAY_HIGH_TICKS(CNT_W'(DHI)), .RELEASE_TICKS(CNT_W'(REL)), .TICK_DIV(DIV)) dut (
      .clk(clk), .reset(reset), .clkEn(clkEn), .key_in_a_n(keyA_n), .key_in_b_n(keyB_n),
      .delaySelect(delaySelect), .resetOut(latchOut), .reset_out_second(latchOut2),
      .timerRunning(latchRun));
   long_press_reset_timer #(.LATCHING(1'b0), .FIXED_DELAY_TICKS(CNT_W'(DLO)),
      .RELEASE_TICKS(CNT_W'(REL)), .TICK_DIV(DIV)) dutAuto (
      .clk(clk), .reset(reset), .clkEn(clkEn), .key_in_a_n(keyA_n), .key_in_b_n(keyB_n),
      .delaySelect(1'b0), .resetOut(autoOut), .reset_out_second(), .timerRunning());
   function automatic int rnd();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return int'(seed[15:0]);
   endfunction
   // cycles from a press to the output edge, one tick of slack below, one tick plus 4 cycles above
   function automatic logic inWin(int got, int ticks);
      return (got >= (ticks - 1) * DIV) && (got <= (ticks + 1) * DIV + 4);
   endfunction
   task automatic print_verdict();
      $display("comparisons %0d mismatches %0d", checks, bad_count);
      if (bad_count == 0 && checks > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask
   task automatic chk(string what, logic [31:0] exp, logic [31:0] got);
      checks++;
      if (got !== exp) begin
         bad_count++;
         $display("[ERR] %s expected %0h seen %0h", what, exp, got);
      end
   endtask
   task automatic press(logic a, logic b);
      @(posedge clk);
      holdA <= a;
      holdB <= b;
   endtask
   task automatic waitFor(logic useAuto, logic lvl, int lim, output int cnt);
      cnt = 0;
      @(negedge clk);
      while ((useAuto ? autoOut : latchOut) !== lvl && cnt < lim) begin
         @(negedge clk);
         cnt++;
      end
      if (cnt >= lim) begin
         chk("bounded wait", 1'b0, 1'b1);
         print_verdict();
      end
   endtask
   task automatic doReset(logic sel);
      @(posedge clk);
      reset <= 1'b1;
      // select firmly driven, changed only in reset
      delaySelect <= sel;
      repeat (6) @(posedge clk);
      reset <= 1'b0;
      @(negedge clk);
   endtask
   initial begin
      clk = 1'b0;
      forever #2.5 clk = ~clk;
   end
   initial begin
      reset = 1'b1;
      delaySelect = 1'b0;
      holdA = 1'b0;
      holdB = 1'b0;
      seed = 32'd70275;
      bad_count = 0;
      checks = 0;
      expPulses = 0;
      clkEn = 1'b1;
      // long select first, so the later tests run with the short delay
      for (i = 0; i < 2; i++) begin
         doReset(i == 0);
         press(1'b1, 1'b1);
         repeat (3) @(negedge clk);
         chk("timer running", 1'b1, latchRun);
         waitFor(1'b0, 1'b1, 200, n);
         chk("latch delay", 1'b1, inWin(n + 3, i ? DLO : DHI));
         chk("second pin", 1'b1, latchOut2);
         repeat (3 * REL * DIV) @(negedge clk);
         chk("latch held", 1'b1, latchOut);
         press(1'b0, 1'b1);
         waitFor(1'b0, 1'b0, 5, n);
         expPulses++;
      end
      $display("test select and hold done");
      for (i = 0; i < 2; i++) begin
         press(i == 0, i == 1);
         repeat ((DLO + 3) * DIV) @(negedge clk);
         chk("one key reset", 1'b0, latchOut);
         chk("one key timer", 1'b0, latchRun);
      end
      $display("test single key done");
      for (i = 0; i < 6; i++) begin
         press(1'b1, 1'b1);
         repeat (rnd() % ((DLO - 2) * DIV) + 1) @(negedge clk);
         r = rnd();
         press(r[0], !r[0]);
         press(1'b1, 1'b1);
         repeat (2) @(negedge clk);
         chk("aborted timer", 1'b0, latchRun);
         chk("aborted press", 1'b0, latchOut);
         waitFor(1'b0, 1'b1, 200, n);
         chk("restart delay", 1'b1, inWin(n + 2, DLO));
         press(1'b0, 1'b1);
         waitFor(1'b0, 1'b0, 5, n);
         expPulses++;
      end
      $display("test abort and restart done");
      // clock enable low holds the timer and the reset output still
      press(1'b1, 1'b1);
      f = rnd() % 8 + 8;
      @(posedge clk);
      clkEn <= 1'b0;
      repeat (f) @(posedge clk);
      clkEn <= 1'b1;
      waitFor(1'b0, 1'b1, 200, n);
      chk("frozen delay", 1'b1, inWin(n + 1, DLO));
      @(posedge clk);
      clkEn <= 1'b0;
      press(1'b0, 1'b1);
      repeat (4) @(negedge clk);
      chk("frozen reset", 1'b1, latchOut);
      @(posedge clk);
      clkEn <= 1'b1;
      waitFor(1'b0, 1'b0, 5, n);
      expPulses++;
      $display("test clock enable done");
      press(1'b1, 1'b1);
      waitFor(1'b1, 1'b1, 200, n);
      chk("auto delay", 1'b1, inWin(n, DLO));
      waitFor(1'b1, 1'b0, 40, n);
      chk("auto release", 1'b1, n >= (REL - 1) * DIV && n <= (REL + 1) * DIV + 2);
      chk("latch after auto", 1'b1, latchOut);
      repeat (4 * DIV) @(negedge clk);
      chk("auto stays low", 1'b0, autoOut);
      press(1'b0, 1'b1);
      press(1'b1, 1'b1);
      waitFor(1'b1, 1'b1, 200, n);
      press(1'b1, 1'b0);
      waitFor(1'b1, 1'b0, 5, n);
      expPulses += 2;
      repeat (4) @(negedge clk);
      chk("reset pulses", CNT_W'(expPulses), CNT_W'(pulses));
      $display("test auto release done");
      print_verdict();
   end
endmodule
